// *** spv_defines.svh ***
// constants for the serial program/verify port
`ifndef SPV_DEFINES_SVH
`define SPV_DEFINES_SVH

// six-bit command codes
`define SPV_CMD_LOAD_CFG   6'h00
`define SPV_CMD_LOAD_PROG  6'h01
`define SPV_CMD_LOAD_DMEM  6'h03
`define SPV_CMD_READ_PROG  6'h04
`define SPV_CMD_READ_DMEM  6'h05
`define SPV_CMD_INC_ADDR   6'h06
`define SPV_CMD_BEGIN_PROG 6'h08

// falling-edge counts inside a command and a data frame
`define SPV_CMD_LAST       4'h5
`define SPV_FRAME_FIRST    4'h0
`define SPV_DATA_FIRST     4'h1
`define SPV_DATA_LAST      4'he
`define SPV_FRAME_LAST     4'hf

// memory pointer values
`define SPV_PTR_RESET      14'h0000
`define SPV_PTR_USER_TOP   14'h1fff
`define SPV_PTR_CFG_BASE   14'h2000
`define SPV_PTR_ID_LAST    14'h2003
`define SPV_PTR_CFG_IMPL   14'h200f
`define SPV_PTR_CFG_TOP    14'h3fff
`define SPV_PTR_HI         13
`define SPV_USER_IDX_W     10

// write request queue
`define SPV_FIFO_DEPTH     16

`endif

// *** spv_pkg.sv ***
// types shared by the serial program/verify port
package spv_pkg;

  typedef logic [13:0] word_t;
  typedef logic [13:0] ptr_t;
  typedef logic [9:0]  idx_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_CMD,
    ST_LOAD,
    ST_READ,
    ST_PUSH
  } state_t;

  typedef enum logic [1:0] {
    OP_LOAD_PROG,
    OP_LOAD_DMEM,
    OP_BEGIN
  } op_t;

  typedef struct packed {
    op_t   op;
    logic  cfg;
    idx_t  idx;
    word_t data;
  } wr_req_t;

endpackage : spv_pkg

// *** spv_link_if.sv ***
// synchronised link events between pin sampler and port logic
`timescale 1ns/10ps
`default_nettype none

interface spv_link_if;
  logic clk_rise;
  logic clk_fall;
  logic data;
  logic mode;
  logic entry;

  modport drv (output clk_rise, output clk_fall, output data, output mode, output entry);
  modport snk (input clk_rise, input clk_fall, input data, input mode, input entry);
endinterface : spv_link_if

`default_nettype wire

// *** spv_pin_sync.sv ***
// two-flop sampling of link pins, edge and entry detection
`timescale 1ns/10ps
`default_nettype none

module spv_pin_sync (
  input  wire logic    i_clk,
  input  wire logic    i_reset_n,
  input  wire logic    i_ce,
  input  wire logic    i_mode_select_pin,
  input  wire logic    i_serial_clock_pin,
  input  wire logic    i_serial_data_pin,
  spv_link_if.drv      lnk
);
  logic [1:0] clk_s_q;
  logic [1:0] dat_s_q;
  logic [1:0] mode_s_q;
  logic       clk_prev_q;
  logic       mode_prev_q;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      clk_s_q     <= 2'h0;
      dat_s_q     <= 2'h0;
      mode_s_q    <= 2'h0;
      clk_prev_q  <= 1'b0;
      mode_prev_q <= 1'b0;
    end else if (i_ce) begin
      clk_s_q     <= {clk_s_q[0], i_serial_clock_pin};
      dat_s_q     <= {dat_s_q[0], i_serial_data_pin};
      mode_s_q    <= {mode_s_q[0], i_mode_select_pin};
      clk_prev_q  <= clk_s_q[1];
      mode_prev_q <= mode_s_q[1];
    end
  end

  assign lnk.clk_rise = clk_s_q[1] & ~clk_prev_q;
  assign lnk.clk_fall = ~clk_s_q[1] & clk_prev_q;
  assign lnk.data     = dat_s_q[1];
  assign lnk.mode     = mode_s_q[1];
  // entry only with clock and data both low
  assign lnk.entry    = mode_s_q[1] & ~mode_prev_q & ~clk_s_q[1] & ~dat_s_q[1];
endmodule : spv_pin_sync

`default_nettype wire

// *** spv_fifo.sv ***
// synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module spv_fifo #(
  parameter int W = 27,
  parameter int D = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_ce,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign o_in_ready  = (cnt_q != (AW+1)'(D));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem[rd_q];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (i_ce) begin
      if (push) begin
        wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : spv_fifo

`default_nettype wire

// *** serial_program_verify_port.sv ***
// device end of the two-wire serial program/verify port
`include "spv_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module serial_program_verify_port (
  input  wire logic            i_clk,
  input  wire logic            i_reset_n,
  input  wire logic            i_ce,
  input  wire logic            i_mode_select_pin,
  input  wire logic            i_serial_clock_pin,
  input  wire logic            i_serial_data_pin,
  output logic                 o_serial_data_pin,
  output logic                 o_serial_data_pin_oe,
  output logic                 o_logic_hold,
  output spv_pkg::ptr_t        o_ptr,
  output logic                 o_rd_cfg,
  output logic                 o_rd_id,
  output logic                 o_rd_dmem,
  output spv_pkg::idx_t        o_rd_index,
  input  wire spv_pkg::word_t  i_rd_data,
  output logic                 o_wr_valid,
  output spv_pkg::op_t         o_wr_op,
  output logic                 o_wr_cfg,
  output spv_pkg::idx_t        o_wr_index,
  output spv_pkg::word_t       o_wr_data,
  input  wire logic            i_wr_ready
);
  import spv_pkg::*;

  // pointer increment keeping the space bit
  function automatic ptr_t inc_ptr(input ptr_t p);
    ptr_t n;
    n = p + 1'b1;
    n[`SPV_PTR_HI] = p[`SPV_PTR_HI];
    return n;
  endfunction : inc_ptr

  // pointer lies in implemented configuration words
  function automatic logic in_cfg(input ptr_t p);
    return (p >= `SPV_PTR_CFG_BASE) && (p <= `SPV_PTR_CFG_IMPL);
  endfunction : in_cfg

  // physical word index behind a pointer
  function automatic idx_t phys_idx(input ptr_t p);
    ptr_t off;
    off = p - `SPV_PTR_CFG_BASE;
    return in_cfg(p) ? off[`SPV_USER_IDX_W-1:0] : p[`SPV_USER_IDX_W-1:0];
  endfunction : phys_idx

  spv_link_if lnk ();

  spv_pin_sync u_sync (
    .i_clk              (i_clk),
    .i_reset_n          (i_reset_n),
    .i_ce               (i_ce),
    .i_mode_select_pin  (i_mode_select_pin),
    .i_serial_clock_pin (i_serial_clock_pin),
    .i_serial_data_pin  (i_serial_data_pin),
    .lnk                (lnk)
  );

  state_t  st_q;
  logic [3:0] cnt_q;
  logic [5:0] cmd_q;
  word_t   sh_q;
  ptr_t    ptr_q;
  op_t     op_q;
  logic    dmem_q;
  logic [5:0] cmd_full;
  logic    cmd_done;
  logic    frame_done;
  wr_req_t fifo_in;
  wr_req_t fifo_out;
  logic    fifo_in_valid;
  logic    fifo_in_ready;
  logic    fifo_out_valid;
  logic    fifo_out_ready;

  assign cmd_full   = {lnk.data, cmd_q[5:1]};
  assign cmd_done   = (st_q == ST_CMD) && lnk.clk_fall && (cnt_q == `SPV_CMD_LAST);
  assign frame_done = lnk.clk_fall && (cnt_q == `SPV_FRAME_LAST);

  // sequencing of commands and frames
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_q <= ST_OFF;
    end else if (i_ce) begin
      if (!lnk.mode) begin
        st_q <= ST_OFF;
      end else begin
        case (st_q)
          ST_OFF: begin
            if (lnk.entry) begin
              st_q <= ST_CMD;
            end
          end
          ST_CMD: begin
            if (cmd_done) begin
              case (cmd_full)
                `SPV_CMD_LOAD_CFG,
                `SPV_CMD_LOAD_PROG,
                `SPV_CMD_LOAD_DMEM: st_q <= ST_LOAD;
                `SPV_CMD_READ_PROG,
                `SPV_CMD_READ_DMEM: st_q <= ST_READ;
                `SPV_CMD_BEGIN_PROG: st_q <= ST_PUSH;
                default: st_q <= ST_CMD;
              endcase
            end
          end
          ST_LOAD: begin
            if (frame_done) begin
              st_q <= ST_PUSH;
            end
          end
          ST_READ: begin
            if (frame_done) begin
              st_q <= ST_CMD;
            end
          end
          ST_PUSH: begin
            if (fifo_in_ready) begin
              st_q <= ST_CMD;
            end
          end
          default: st_q <= ST_OFF;
        endcase
      end
    end
  end

  // falling-edge count within command or frame
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cnt_q <= `SPV_FRAME_FIRST;
    end else if (i_ce) begin
      if (!lnk.mode || cmd_done || st_q == ST_OFF || st_q == ST_PUSH) begin
        cnt_q <= `SPV_FRAME_FIRST;
      end else if (lnk.clk_fall) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // command shifter, first bit lands in bit 0
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cmd_q <= '0;
    end else if (i_ce && st_q == ST_CMD && lnk.clk_fall) begin
      cmd_q <= cmd_full;
    end
  end

  // pending operation and memory kind
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      op_q   <= OP_LOAD_PROG;
      dmem_q <= 1'b0;
    end else if (i_ce && cmd_done) begin
      if (cmd_full == `SPV_CMD_LOAD_DMEM) begin
        op_q <= OP_LOAD_DMEM;
      end else if (cmd_full == `SPV_CMD_BEGIN_PROG) begin
        op_q <= OP_BEGIN;
      end else begin
        op_q <= OP_LOAD_PROG;
      end
      dmem_q <= (cmd_full == `SPV_CMD_READ_DMEM) || (cmd_full == `SPV_CMD_LOAD_DMEM);
    end
  end

  // memory pointer
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ptr_q <= `SPV_PTR_RESET;
    end else if (i_ce) begin
      if (st_q == ST_OFF && lnk.entry) begin
        ptr_q <= `SPV_PTR_RESET;
      end else if (cmd_done && cmd_full == `SPV_CMD_LOAD_CFG) begin
        ptr_q <= `SPV_PTR_CFG_BASE;
      end else if (cmd_done && cmd_full == `SPV_CMD_INC_ADDR) begin
        ptr_q <= inc_ptr(ptr_q);
      end
    end
  end

  // data shifter: load samples on falls, read shifts on rises
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sh_q <= '0;
    end else if (i_ce) begin
      if (st_q == ST_LOAD && lnk.clk_fall &&
          cnt_q >= `SPV_DATA_FIRST && cnt_q <= `SPV_DATA_LAST) begin
        sh_q <= {lnk.data, sh_q[13:1]};
      end else if (st_q == ST_READ && lnk.clk_rise) begin
        if (cnt_q == `SPV_FRAME_FIRST) begin
          sh_q <= i_rd_data;
        end else if (cnt_q <= `SPV_DATA_LAST) begin
          sh_q <= {1'b0, sh_q[13:1]};
        end
      end
    end
  end

  // data pin driver
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_serial_data_pin    <= 1'b0;
      o_serial_data_pin_oe <= 1'b0;
    end else if (i_ce) begin
      if (st_q != ST_READ || !lnk.mode) begin
        o_serial_data_pin    <= 1'b0;
        o_serial_data_pin_oe <= 1'b0;
      end else if (lnk.clk_rise) begin
        if (cnt_q >= `SPV_DATA_FIRST && cnt_q <= `SPV_DATA_LAST) begin
          o_serial_data_pin    <= sh_q[0];
          o_serial_data_pin_oe <= 1'b1;
        end else if (cnt_q == `SPV_FRAME_LAST) begin
          o_serial_data_pin    <= 1'b0;
          o_serial_data_pin_oe <= 1'b0;
        end
      end
    end
  end

  // hold of the rest of the device and read addressing
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_logic_hold <= 1'b0;
      o_ptr        <= `SPV_PTR_RESET;
      o_rd_cfg     <= 1'b0;
      o_rd_id      <= 1'b0;
      o_rd_dmem    <= 1'b0;
      o_rd_index   <= '0;
    end else if (i_ce) begin
      o_logic_hold <= (st_q != ST_OFF);
      o_ptr        <= ptr_q;
      o_rd_cfg     <= in_cfg(ptr_q);
      o_rd_id      <= (ptr_q >= `SPV_PTR_CFG_BASE) && (ptr_q <= `SPV_PTR_ID_LAST);
      o_rd_dmem    <= dmem_q;
      o_rd_index   <= phys_idx(ptr_q);
    end
  end

  assign fifo_in_valid = (st_q == ST_PUSH);
  assign fifo_in.op    = op_q;
  assign fifo_in.cfg   = in_cfg(ptr_q);
  assign fifo_in.idx   = phys_idx(ptr_q);
  assign fifo_in.data  = sh_q;

  spv_fifo #(
    .W ($bits(wr_req_t)),
    .D (`SPV_FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_ce        (i_ce),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out)
  );

  assign fifo_out_ready = !o_wr_valid || i_wr_ready;

  // registered write request stage
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_wr_valid <= 1'b0;
      o_wr_op    <= OP_LOAD_PROG;
      o_wr_cfg   <= 1'b0;
      o_wr_index <= '0;
      o_wr_data  <= '0;
    end else if (i_ce && fifo_out_ready) begin
      o_wr_valid <= fifo_out_valid;
      if (fifo_out_valid) begin
        o_wr_op    <= fifo_out.op;
        o_wr_cfg   <= fifo_out.cfg;
        o_wr_index <= fifo_out.idx;
        o_wr_data  <= fifo_out.data;
      end
    end
  end

  a_entry_ptr_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    (st_q == ST_OFF && lnk.mode && lnk.entry) |=> (ptr_q == `SPV_PTR_RESET && st_q == ST_CMD))
    else $error("pointer not zero after entry");
  a_cfg_load_base: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    (lnk.mode && cmd_done && cmd_full == `SPV_CMD_LOAD_CFG) |=>
    (ptr_q == `SPV_PTR_CFG_BASE && st_q == ST_LOAD))
    else $error("load configuration did not set base");
  a_user_wrap: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    (lnk.mode && cmd_done && cmd_full == `SPV_CMD_INC_ADDR && ptr_q == `SPV_PTR_USER_TOP) |=>
    (ptr_q == `SPV_PTR_RESET))
    else $error("user space did not wrap to zero");
  a_cfg_wrap: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    (lnk.mode && cmd_done && cmd_full == `SPV_CMD_INC_ADDR && ptr_q == `SPV_PTR_CFG_TOP) |=>
    (ptr_q == `SPV_PTR_CFG_BASE))
    else $error("config space did not wrap to base");
  a_cfg_sticky: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    (ptr_q[`SPV_PTR_HI] && st_q != ST_OFF) |=> (ptr_q[`SPV_PTR_HI] || $past(st_q) == ST_OFF))
    else $error("pointer left config space");
  a_read_oe_on: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    (lnk.mode && st_q == ST_READ && lnk.clk_rise && cnt_q == `SPV_DATA_FIRST) |=>
    (o_serial_data_pin_oe && o_serial_data_pin == $past(sh_q[0])))
    else $error("read did not drive at second rise");
  a_read_oe_off: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    (st_q == ST_READ && lnk.clk_rise && cnt_q == `SPV_FRAME_LAST) |=> !o_serial_data_pin_oe)
    else $error("read still driving after sixteenth rise");
  a_pin_idle_input: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    (st_q != ST_READ) |=> !o_serial_data_pin_oe)
    else $error("data pin driven outside read");
  a_abort_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    (!lnk.mode) |=> (st_q == ST_OFF) ##1 (!o_logic_hold))
    else $error("mode low did not abort");
  a_user_alias: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    (!ptr_q[`SPV_PTR_HI]) |=> (!o_rd_cfg && o_rd_index == $past(ptr_q[`SPV_USER_IDX_W-1:0])))
    else $error("user address not aliased to ten bits");
  a_cmd_six_falls: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_ce)
    cmd_done |=> (cnt_q == `SPV_FRAME_FIRST && cmd_q == $past(cmd_full)))
    else $error("command not taken after six falls");

endmodule : serial_program_verify_port

`default_nettype wire

// *** spv_prog_model.sv ***
// programmer model: serial clock, data and mode pins
`timescale 1ns/10ps
`default_nettype none

module spv_prog_model (
  input  wire logic i_clk,
  input  wire logic i_pin,
  output logic      o_mode,
  output logic      o_sclk,
  output logic      o_sdat,
  output logic      o_sdat_oe
);
  initial begin
    o_mode    = 1'b0;
    o_sclk    = 1'b0;
    o_sdat    = 1'b0;
    o_sdat_oe = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask : tick

  task automatic enter();
    o_mode <= 1'b0;
    tick(8);
    o_sclk    <= 1'b0;
    o_sdat    <= 1'b0;
    o_sdat_oe <= 1'b1;
    tick(4);
    // step rise: no oscillator clocks between the two levels
    o_mode <= 1'b1;
    tick(80);
  endtask : enter

  task automatic leave();
    o_mode <= 1'b0;
    tick(8);
  endtask : leave

  // n cycles lsb first; read frames release the pin and sample late in the low phase
  task automatic shift(input logic [15:0] bits, input int n, input logic rd, output logic [13:0] got);
    got = '0;
    o_sdat_oe <= ~rd;
    for (int k = 0; k < n; k++) begin
      o_sclk <= 1'b1;
      o_sdat <= bits[k];
      tick(4);
      o_sclk <= 1'b0;
      tick(3);
      if (rd && k >= 1 && k <= 14) got[k-1] = i_pin;
      tick(1);
    end
    tick(48);
  endtask : shift
endmodule : spv_prog_model

`default_nettype wire

// *** tb.sv ***
// self-checking bench for the serial program/verify port
`include "spv_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module tb;
  import spv_pkg::*;
  logic        i_clk, i_reset_n, i_wr_ready, stall, last_lvl;
  logic        p_mode, p_sclk, p_sdat, p_oe, d_pin, d_oe, hold, rd_cfg, rd_id, rd_dmem, wr_valid, wr_cfg;
  ptr_t        ptr, ptr_m;
  idx_t        rd_index, wr_index;
  word_t       wr_data, rd_data, last_w;
  op_t         wr_op;
  logic [31:0] seed, rdy_seed;
  int          errors, checks_done;
  wr_req_t     exp_q[$];
  wire         sdat = p_oe ? p_sdat : (d_oe ? d_pin : ~last_lvl);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic word_t mem_word(input idx_t i, input logic c, input logic m);
    return m ? {4'h9, i} : {c, 3'h2, i};
  endfunction : mem_word
  function automatic logic phys_cfg(input ptr_t p);
    return p[13] && (p <= `SPV_PTR_CFG_IMPL);
  endfunction : phys_cfg
  function automatic idx_t phys_idx(input ptr_t p);
    return phys_cfg(p) ? idx_t'(p - `SPV_PTR_CFG_BASE) : p[9:0];
  endfunction : phys_idx
  function automatic ptr_t next_ptr(input ptr_t p);
    if (p == `SPV_PTR_USER_TOP) return `SPV_PTR_RESET;
    if (p == `SPV_PTR_CFG_TOP) return `SPV_PTR_CFG_BASE;
    return p + 14'h0001;
  endfunction : next_ptr

  initial i_clk = 1'b0;
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) last_lvl <= sdat;
  assign rd_data = mem_word(rd_index, rd_cfg, rd_dmem);
  always @(negedge i_clk) begin
    rdy_seed = lfsr(rdy_seed);
    i_wr_ready <= ~stall & rdy_seed[3];
  end

  spv_prog_model prog (.i_clk(i_clk), .i_pin(sdat), .o_mode(p_mode), .o_sclk(p_sclk), .o_sdat(p_sdat),
                       .o_sdat_oe(p_oe));

  serial_program_verify_port dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(1'b1), .i_mode_select_pin(p_mode),
    .i_serial_clock_pin(p_sclk), .i_serial_data_pin(sdat), .o_serial_data_pin(d_pin),
    .o_serial_data_pin_oe(d_oe), .o_logic_hold(hold), .o_ptr(ptr), .o_rd_cfg(rd_cfg), .o_rd_id(rd_id),
    .o_rd_dmem(rd_dmem), .o_rd_index(rd_index), .i_rd_data(rd_data), .o_wr_valid(wr_valid),
    .o_wr_op(wr_op), .o_wr_cfg(wr_cfg), .o_wr_index(wr_index), .o_wr_data(wr_data), .i_wr_ready(i_wr_ready));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  always @(posedge i_clk) begin
    if (i_reset_n && wr_valid && i_wr_ready) begin
      if (exp_q.size() == 0) chk("wr_extra", 32'h0, 32'h1);
      else chk("wr_req", 32'(exp_q.pop_front()), 32'({wr_op, wr_cfg, wr_index, wr_data}));
    end
  end

  task automatic entry_check();
    chk("hold", 32'h1, 32'(hold));
    chk("oe", 32'h0, 32'(d_oe));
    chk("ptr", 32'h0, 32'(ptr));
  endtask : entry_check

  task automatic do_cmd(input logic [5:0] code);
    logic [13:0] got;
    logic [13:0] w;
    logic [31:0] r;
    seed = lfsr(seed);
    r = seed;
    w = r[13:0];
    if (code == `SPV_CMD_LOAD_CFG) begin
      ptr_m = `SPV_PTR_CFG_BASE;
      w = {10'h3f8, r[3:0]};
    end
    if (code == `SPV_CMD_INC_ADDR) ptr_m = next_ptr(ptr_m);
    if (code == `SPV_CMD_LOAD_CFG || code == `SPV_CMD_LOAD_PROG) exp_q.push_back({OP_LOAD_PROG, phys_cfg(ptr_m),
      phys_idx(ptr_m), w});
    if (code == `SPV_CMD_LOAD_DMEM) exp_q.push_back({OP_LOAD_DMEM, phys_cfg(ptr_m), ptr_m[9:0], w});
    if (code == `SPV_CMD_BEGIN_PROG) exp_q.push_back({OP_BEGIN, phys_cfg(ptr_m), phys_idx(ptr_m), last_w});
    prog.shift({10'h0, code}, 6, 1'b0, got);
    if (code inside {`SPV_CMD_LOAD_CFG, `SPV_CMD_LOAD_PROG, `SPV_CMD_LOAD_DMEM}) begin
      last_w = w;
      prog.shift({r[31], w, r[30]}, 16, 1'b0, got);
    end
    if (code inside {`SPV_CMD_READ_PROG, `SPV_CMD_READ_DMEM}) begin
      prog.shift(16'h0, 16, 1'b1, got);
      if (code == `SPV_CMD_READ_DMEM) chk("read", 32'(mem_word(ptr_m[9:0], 1'b0, 1'b1)), 32'(got));
      else chk("read", 32'(mem_word(phys_idx(ptr_m), phys_cfg(ptr_m), 1'b0)), 32'(got));
      chk("oe_after", 32'h0, 32'(d_oe));
    end
    chk("ptr", 32'(ptr_m), 32'(ptr));
  endtask : do_cmd

  task automatic summarize();
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  initial begin
    repeat (70000) @(posedge i_clk);
    errors++;
    summarize();
  end

  initial begin
    logic [5:0]  tbl[9];
    logic [13:0] got;
    logic [5:0]  pick;
    tbl = '{6'h01, 6'h04, 6'h06, 6'h03, 6'h05, 6'h08, 6'h09, 6'h00, 6'h3f};
    seed = 32'd78219;
    rdy_seed = 32'd78219;
    errors = 0;
    checks_done = 0;
    stall = 1'b0;
    i_wr_ready = 1'b0;
    last_lvl = 1'b0;
    last_w = '0;
    ptr_m = '0;
    i_reset_n = 1'b0;
    repeat (20) @(negedge i_clk);
    i_reset_n <= 1'b1;
    prog.enter();
    entry_check();
    for (int i = 0; i < 30; i++) begin
      seed = lfsr(seed);
      pick = (i < 9) ? tbl[i] : tbl[seed % 9];
      if (pick == `SPV_CMD_BEGIN_PROG) do_cmd(`SPV_CMD_LOAD_PROG);
      do_cmd(pick);
    end
    prog.leave();
    chk("hold_off", 32'h0, 32'(hold));
    prog.enter();
    ptr_m = '0;
    entry_check();
    do_cmd(`SPV_CMD_LOAD_CFG);
    for (int i = 0; i < 17; i++) begin
      chk("rd_cfg", 32'(phys_cfg(ptr_m)), 32'(rd_cfg));
      chk("rd_id", 32'(ptr_m <= `SPV_PTR_ID_LAST), 32'(rd_id));
      do_cmd(`SPV_CMD_INC_ADDR);
    end
    do_cmd(`SPV_CMD_LOAD_PROG);
    prog.shift(16'h0006, 3, 1'b0, got);
    prog.leave();
    prog.enter();
    ptr_m = '0;
    entry_check();
    do_cmd(`SPV_CMD_INC_ADDR);
    stall = 1'b1;
    for (int i = 0; i < 16; i++) do_cmd(`SPV_CMD_LOAD_PROG);
    chk("held_valid", 32'h1, 32'(wr_valid));
    stall = 1'b0;
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge i_clk);
    chk("drained", 32'h0, 32'(exp_q.size()));
    summarize();
  end
endmodule : tb

`default_nettype wire
